// ---- adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;

   // ---------------------------------------------------------------
   // register map (word indices on the plain register port)
   // ---------------------------------------------------------------
   localparam logic [3:0] result_addr = 4'h0;
   localparam logic [3:0] config_addr = 4'h1;
   localparam logic [3:0] status_addr = 4'h2;

   // ---------------------------------------------------------------
   // config field positions
   // ---------------------------------------------------------------
   localparam int start_bit = 15;
   localparam int mux_lsb = 12;
   localparam int gain_lsb = 9;
   localparam int cont_bit = 8;
   localparam int rate_lsb = 5;
   localparam int temp_bit = 4;
   localparam logic [15:0] config_reset = 16'h858B;

   // ---------------------------------------------------------------
   // conversion timing, cycles of the 25 MHz clock
   // ---------------------------------------------------------------
   localparam int clk_hz = 25000000;
   localparam int rate_8_sps = 8;
   localparam logic [21:0] conv_cycles_min = 22'(clk_hz / 860);
   localparam logic [21:0] conv_cycles_max = 22'(clk_hz / rate_8_sps);

   // ---------------------------------------------------------------
   // codes
   // ---------------------------------------------------------------
   localparam logic [15:0] code_pos_max = 16'h7FFF;
   localparam logic [15:0] code_neg_max = 16'h8000;
   localparam logic [2:0] mux_se_first = 3'h4;

   typedef enum logic [1:0] {
      st_down = 2'b00,
      st_convert = 2'b01
   } conv_state_t;

endpackage : adc_ctrl_pkg

// ---- adc_link_if.sv ----
interface adc_link_if;
   logic [15:0] raw_code;
   logic [13:0] temp_code;
   logic temp_sel;
   logic [15:0] code;
   modport fmt(input raw_code, input temp_code, input temp_sel,
      output code);
   modport ctl(output raw_code, output temp_code, output temp_sel,
      input code);
endinterface : adc_link_if

// ---- result_formatter.sv ----
module result_formatter (
   adc_link_if.fmt link
);
   always_comb begin
      if (link.temp_sel) begin
         link.code = {link.temp_code, 2'b00};
      end else begin
         link.code = link.raw_code;
      end
   end
endmodule : result_formatter

// ---- adc_conversion_format_control.sv ----
// Our own choices: strobed register access and the register addresses.
module adc_conversion_format_control
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   // modulator side, sample from outside clock domain
   input wire logic [16:0] modulator_value,
   input wire logic [13:0] sensor_value,
   // analog front end controls and data ready
   output logic [2:0] positive_converter_input,
   output logic [2:0] negative_converter_input,
   output logic [2:0] full_scale_range,
   output logic sensor_enable,
   output logic powered,
   output logic data_ready
);

   // ---------------------------------------------------------------
   // mux and gain decoding
   // ---------------------------------------------------------------
   // input codes: 0..3 analog_input_0..3, 4 ground
   function automatic logic [5:0] mux_decode(input logic [2:0] sel);
      logic [5:0] r;
      r = 6'h00;
      case (sel)
         3'h0: r = {3'h0, 3'h1};
         3'h1: r = {3'h0, 3'h3};
         3'h2: r = {3'h1, 3'h3};
         3'h3: r = {3'h2, 3'h3};
         3'h4: r = {3'h0, 3'h4};
         3'h5: r = {3'h1, 3'h4};
         3'h6: r = {3'h2, 3'h4};
         default: r = {3'h3, 3'h4};
      endcase
      return r;
   endfunction : mux_decode

   // full-scale codes 0..5: 6.144, 4.096, 2.048, 1.024, 0.512, 0.256 V
   function automatic logic [2:0] gain_decode(input logic [2:0] g);
      return (g > 3'h5) ? 3'h5 : g;
   endfunction : gain_decode

   // conversion period per rate code: 8..860 samples per second
   function automatic logic [21:0] rate_cycles(input logic [2:0] r);
      logic [21:0] c;
      c = conv_cycles_max;
      case (r)
         3'h0: c = conv_cycles_max;
         3'h1: c = 22'(clk_hz / 16);
         3'h2: c = 22'(clk_hz / 32);
         3'h3: c = 22'(clk_hz / 64);
         3'h4: c = 22'(clk_hz / 128);
         3'h5: c = 22'(clk_hz / 250);
         3'h6: c = 22'(clk_hz / 475);
         default: c = conv_cycles_min;
      endcase
      return c;
   endfunction : rate_cycles

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      conv_state_t st;
      logic [15:0] cfg;
      logic [21:0] count;
      logic [15:0] result;
      logic [16:0] mod_s1;
      logic [16:0] mod_s2;
      logic [13:0] temp_s1;
      logic [13:0] temp_s2;
      logic written;
      logic [15:0] rdata;
      logic [2:0] pos;
      logic [2:0] neg;
      logic [2:0] fs;
      logic sens;
      logic pwr;
      logic rdy;
   } state_t;

   state_t q;
   state_t next_q;
   adc_link_if link();
   logic [16:0] sat_raw;

   result_formatter u_fmt (
      .link(link.fmt)
   );

   // ---------------------------------------------------------------
   // saturation of modulator value to 16 bits
   // ---------------------------------------------------------------
   always_comb begin
      sat_raw = q.mod_s2;
      if (!sat_raw[16] && sat_raw[15]) begin
         link.raw_code = code_pos_max;
      end else if (sat_raw[16] && !sat_raw[15]) begin
         link.raw_code = code_neg_max;
      end else begin
         link.raw_code = sat_raw[15:0];
      end
      link.temp_code = q.temp_s2;
      link.temp_sel = q.cfg[temp_bit];
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_q = q;
      next_q.mod_s1 = modulator_value;
      next_q.mod_s2 = q.mod_s1;
      next_q.temp_s1 = sensor_value;
      next_q.temp_s2 = q.temp_s1;
      next_q.rdy = 1'b0;

      if (wr && addr == config_addr) begin
         next_q.cfg = {q.cfg[start_bit], wdata[14:0]};
         next_q.written = 1'b1;
         // a start written while converting is dropped
         if (wdata[start_bit] && q.st == st_down) begin
            next_q.cfg[start_bit] = 1'b0;
         end
      end

      case (q.st)
         st_down: begin
            next_q.count = '0;
            if (next_q.written &&
               (!next_q.cfg[start_bit] || !next_q.cfg[cont_bit])) begin
               next_q.st = st_convert;
               next_q.cfg[start_bit] = 1'b0;
            end
         end
         st_convert: begin
            next_q.count = q.count + 22'h000001;
            if (q.count + 22'h000001 >=
               rate_cycles(q.cfg[rate_lsb +: 3])) begin
               next_q.result = link.code;
               next_q.rdy = 1'b1;
               next_q.count = '0;
               if (q.cfg[cont_bit]) begin
                  next_q.st = st_down;
                  next_q.cfg[start_bit] = 1'b1;
                  // a config write in this very cycle still counts
                  next_q.written = wr && addr == config_addr;
               end else begin
                  next_q.st = st_convert;
               end
            end
         end
         default: next_q.st = st_down;
      endcase

      {next_q.pos, next_q.neg} = mux_decode(q.cfg[mux_lsb +: 3]);
      next_q.fs = gain_decode(q.cfg[gain_lsb +: 3]);
      next_q.sens = q.cfg[temp_bit];
      next_q.pwr = (next_q.st == st_convert);

      next_q.rdata = 16'h0000;
      if (rd) begin
         case (addr)
            result_addr: next_q.rdata = q.result;
            config_addr: next_q.rdata = q.cfg;
            status_addr: next_q.rdata = {15'h0000, q.pwr};
            default: next_q.rdata = 16'h0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{st: st_down, cfg: config_reset, default: '0};
      end else begin
         q <= next_q;
      end
   end

   assign rdata = q.rdata;
   assign positive_converter_input = q.pos;
   assign negative_converter_input = q.neg;
   assign full_scale_range = q.fs;
   assign sensor_enable = q.sens;
   assign powered = q.pwr;
   assign data_ready = q.rdy;

endmodule : adc_conversion_format_control

// ---- afe_model.sv ----
module afe_model (
   // control from the block
   input wire logic powered,
   input wire logic sensor_enable,
   // levels chosen by the bench
   input wire logic [16:0] level,
   input wire logic [13:0] temp,
   // samples towards the block
   output logic [16:0] modulator_value,
   output logic [13:0] sensor_value
);
   timeunit 1ns;
   timeprecision 1ns;
   // an idle or unselected source shows a value that must never be latched
   assign modulator_value = powered && !sensor_enable ? level : ~level;
   assign sensor_value = powered && sensor_enable ? temp : ~temp;
endmodule : afe_model

// ---- adc_ctrl_sva.sv ----
module adc_ctrl_sva
   import adc_ctrl_pkg::*;
(
   // clock
   input wire logic clk,
   input wire logic rst_n,
   // bus
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   // converter
   input wire logic [16:0] modulator_value,
   input wire logic [13:0] sensor_value,
   input wire logic [2:0] positive_converter_input,
   input wire logic [2:0] negative_converter_input,
   input wire logic [2:0] full_scale_range,
   input wire logic sensor_enable,
   input wire logic powered,
   input wire logic data_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic single;
   logic cfg_wr;
   assign cfg_wr = wr && addr == config_addr;
   // mode of the last configuration write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         single <= config_reset[cont_bit];
      else if (cfg_wr)
         single <= wdata[cont_bit];
   end
   chk_ready_pulse: assert property (data_ready |=> !data_ready)
      else $error("data ready longer than one cycle");
   chk_shot_sleeps: assert property (
      data_ready && single && !cfg_wr |=> !powered)
      else $error("still powered after single conversion");
   chk_cont_rolls: assert property (
      data_ready && !single && !cfg_wr |=> powered)
      else $error("continuous conversion stopped");
   chk_start_wakes: assert property (cfg_wr && !powered &&
      (wdata[start_bit] || !wdata[cont_bit]) |=> powered)
      else $error("requested conversion not started");
   chk_start_ignored: assert property (cfg_wr && powered ##1 !data_ready |-> powered)
      else $error("write during conversion stopped it");
   // front end controls follow the config register one cycle later
   chk_se_ground: assert property (cfg_wr && wdata[14] |-> ##2
      negative_converter_input == 3'h4 &&
      positive_converter_input == {1'b0, $past(wdata[13:12], 2)})
      else $error("single ended selection wrong");
   chk_gain_range: assert property (cfg_wr |-> ##2
      full_scale_range == ($past(wdata[11:9], 2) > 3'h5 ?
      3'h5 : $past(wdata[11:9], 2)))
      else $error("full scale range wrong");
   chk_source_sel: assert property (cfg_wr |-> ##2
      sensor_enable == $past(wdata[temp_bit], 2))
      else $error("source selection wrong");
   chk_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
      else $error("read data outside read cycle");
   cover property (data_ready && single);
   cover property (data_ready && !single && sensor_enable);
   cover property (cfg_wr && powered && wdata[start_bit]);
endmodule : adc_ctrl_sva

bind adc_conversion_format_control adc_ctrl_sva chk (.clk(clk), .rst_n(rst_n),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .modulator_value(modulator_value), .sensor_value(sensor_value),
   .positive_converter_input(positive_converter_input),
   .negative_converter_input(negative_converter_input),
   .full_scale_range(full_scale_range), .sensor_enable(sensor_enable),
   .powered(powered), .data_ready(data_ready));

// ---- tb.sv ----
module tb
   import adc_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata, d;
   logic [16:0] level = 17'h10000, mod_val;
   logic [13:0] temp = 14'h3CE0, sens_val;
   logic [2:0] pos, neg, fsr;
   logic sens_en, powered, data_ready;
   int failures = 0, n_compared = 0, cycles = 0, t0, n;
   always #20 clk = ~clk;
   adc_conversion_format_control dut (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .modulator_value(mod_val), .sensor_value(sens_val),
      .positive_converter_input(pos), .negative_converter_input(neg),
      .full_scale_range(fsr), .sensor_enable(sens_en), .powered(powered),
      .data_ready(data_ready));
   afe_model afe (.powered(powered), .sensor_enable(sens_en), .level(level),
      .temp(temp), .modulator_value(mod_val), .sensor_value(sens_val));
   task automatic chk(string what, logic [21:0] seen, logic [21:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic put(logic [3:0] a, logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : put
   task automatic get(logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : get
   task automatic await(int lim);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (data_ready !== 1'b1 && n < lim);
   endtask : await
   task automatic t_mux;
      logic [2:0] pt[8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h0, 3'h1, 3'h2, 3'h3};
      logic [2:0] nt[8] = '{3'h1, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4};
      get(config_addr);
      chk("config reset", d, config_reset);
      get(4'hF);
      chk("unmapped", d, 16'h0000);
      for (int m = 0; m < 8; m++) begin
         put(config_addr, {1'b0, 3'(m), 3'(m), 9'h1E3});
         @(posedge clk);
         #1;
         chk("pos in", pos, pt[m]);
         chk("neg in", neg, nt[m]);
         chk("range", fsr, m > 5 ? 3'h5 : 3'(m));
         chk("no start", powered, 1'b0);
      end
   endtask : t_mux
   task automatic t_single;
      put(config_addr, 16'h81E3);
      t0 = cycles;
      chk("busy", powered, 1'b1);
      get(config_addr);
      chk("busy flag", d[15], 1'b0);
      put(config_addr, 16'h81E3);
      await(conv_cycles_min + 20);
      chk("shot time", 22'(cycles - t0), conv_cycles_min);
      get(result_addr);
      chk("clip low", d, code_neg_max);
      get(config_addr);
      chk("done flag", d[15], 1'b1);
      chk("asleep", powered, 1'b0);
      await(200);
      chk("one shot", 22'(n), 22'h0000C8);
   endtask : t_single
   task automatic t_cont;
      put(config_addr, 16'h00F3);
      await(conv_cycles_min + 20);
      get(result_addr);
      chk("temp msb", d[15:8], 8'hF3);
      chk("temp lsb", d[7:0], 8'h80);
      temp <= 14'h0640;
      await(conv_cycles_min + 20);
      chk("rate", 22'(n), conv_cycles_min - 22'h000002);
      get(result_addr);
      chk("temp pos", d, 16'h1900);
      chk("rolling", powered, 1'b1);
   endtask : t_cont
   task automatic t_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("reset power", powered, 1'b0);
      get(config_addr);
      chk("reset config", d, config_reset);
      await(100);
      chk("idle after reset", 22'(n), 22'h000064);
   endtask : t_reset
   task automatic final_report;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   always @(posedge clk) begin
      cycles++;
      if (cycles == 95000) begin
         failures++;
         final_report;
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_mux;
      t_single;
      t_cont;
      t_reset;
      final_report;
   end
endmodule : tb
